/* File: common/pwr_hs_pkg.sv */
// Purpose: Shared constants for the radio host power handshake block
// Assumes: Register port with 4-bit byte address, 32-bit data
// Notes: All offsets are byte addresses, one aligned word each
package pwr_hs_pkg;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] PWRDN_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  // Control field positions
  localparam int DEV_WAKE_POL_BIT = 0;
  localparam int HOST_WAKE_POL_BIT = 1;
  localparam int SW_HOST_WAKE_BIT = 2;
  localparam int SW_CLK_REQ_BIT = 3;
  localparam int SLEEP_OK_BIT = 4;
  localparam int UART_MODE_BIT = 5;
  localparam int PKT_AUTO_BIT = 6;
  localparam logic [6:0] CTRL_RESET = 7'h60;
  // Power-down field positions: tx, rx, pll, pa
  localparam int PD_TX_BIT = 0;
  localparam int PD_RX_BIT = 1;
  localparam int PD_PLL_BIT = 2;
  localparam int PD_PA_BIT = 3;
  localparam logic [3:0] PWRDN_RESET = 4'hf;
  localparam logic [3:0] PWRDN_ALL = 4'hf;
  localparam logic [3:0] PWRDN_RX_ON = 4'h9;
  localparam logic [3:0] PWRDN_TX_ON = 4'h2;
  typedef enum logic [1:0] {PWR_SLEEP, PWR_AWAKE} pwr_state_e;
endpackage

/* File: common/pwr_sync_if.sv */
`timescale 1ns/1ps
// Purpose: Carrier between top and wake synchroniser
// Assumes: Single clock domain
// Notes: Raw pin in, synchronised level out
interface pwr_sync_if;
  logic rawLevel;
  logic syncLevel;
  modport top (output rawLevel, input syncLevel);
  modport sync (input rawLevel, output syncLevel);
endinterface

/* File: hdl/radio_host_power_handshake.sv */
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Purpose: Host wake handshake, clock request and radio power-down control
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Wake pin is raw pin level; polarity applied after synchronising
// Notes on behaviour
// R1 - Sideband wake signals active only while serial transport mode is enabled.
// R2 - Asserted device-wake forces awake state, or keeps it awake.
// R3 - Deasserted device-wake allows sleep only when sleep criteria are met.
// R4 - Software bits select polarity of device-wake input and host-wake output.
// R5 - Device raises host-wake when it needs host attention; host must wake.
// R6 - Host may sleep once host-wake drops and its own criteria hold.
// R7 - Clock request is raised when any radio function needs reference clock.
// R8 - Clock request is always active high, never inverted.
// R9 - Separate power-down outputs for tx path, rx path, PLL and PA.
// R10 - Power actions come from software registers or packet-handling logic.
// R11 - Packet handling switches radio power on and off within packet periods.
// R12 - Wake input is synchronised; outputs deasserted after reset. Here the four power-down outputs reset high, all paths down.
module radio_host_power_handshake (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic device_wake_in,
  input wire logic attentionReq,
  input wire logic radioClkNeed,
  input wire logic txActive,
  input wire logic rxActive,
  output logic host_wake_out,
  output logic clkReq,
  output logic txPowerDown,
  output logic rxPowerDown,
  output logic pllPowerDown,
  output logic paPowerDown,
  output logic awake
);
  logic [6:0] ctrl_q, ctrl_d;
  logic [3:0] pwrdn_q, pwrdn_d;
  logic [31:0] rdata_q, rdata_d;
  pwr_hs_pkg::pwr_state_e state_q, state_d;
  logic hostWake_q, hostWake_d;
  logic clkReq_q, clkReq_d;
  logic awake_q, awake_d;
  logic [3:0] pdOut_q, pdOut_d;
  logic wakeAsserted;
  logic uartMode;
  logic [3:0] pktPd;

  pwr_sync_if syncLink ();

  // R12 sync wake pin
  assign syncLink.rawLevel = device_wake_in;

  wake_sync wakeSync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .link(syncLink.sync)
  );

  assign uartMode = ctrl_q[pwr_hs_pkg::UART_MODE_BIT];
  // R4 input polarity, 1 means active high
  assign wakeAsserted = uartMode &&
    (syncLink.syncLevel == ctrl_q[pwr_hs_pkg::DEV_WAKE_POL_BIT]);

  // R11 packet-driven power gating
  always_comb
  begin
    pktPd = pwr_hs_pkg::PWRDN_ALL;
    if (txActive)
    begin
      pktPd = pktPd & pwr_hs_pkg::PWRDN_TX_ON;
    end
    if (rxActive)
    begin
      pktPd = pktPd & pwr_hs_pkg::PWRDN_RX_ON;
    end
  end

  // R10 register writes and reads
  always_comb
  begin
    ctrl_d = ctrl_q;
    pwrdn_d = pwrdn_q;
    rdata_d = 32'h0;
    if (regWrite)
    begin
      case (regAddr)
        pwr_hs_pkg::CTRL_OFFSET: ctrl_d = regWdata[6:0];
        pwr_hs_pkg::PWRDN_OFFSET: pwrdn_d = regWdata[3:0];
        default: ;
      endcase
    end
    if (regRead)
    begin
      case (regAddr)
        pwr_hs_pkg::CTRL_OFFSET: rdata_d = {25'h0, ctrl_q};
        pwr_hs_pkg::PWRDN_OFFSET: rdata_d = {28'h0, pwrdn_q};
        pwr_hs_pkg::STATUS_OFFSET: rdata_d = {24'h0, pdOut_q, clkReq_q, hostWake_q,
          syncLink.syncLevel, state_q == pwr_hs_pkg::PWR_AWAKE};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // Sleep/awake state and outputs
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      pwr_hs_pkg::PWR_SLEEP:
      begin
        // R2 wake on request
        if (wakeAsserted || attentionReq || !uartMode)
        begin
          state_d = pwr_hs_pkg::PWR_AWAKE;
        end
      end
      pwr_hs_pkg::PWR_AWAKE:
      begin
        // R3 sleep needs criteria
        if (uartMode && !wakeAsserted && !attentionReq && ctrl_q[pwr_hs_pkg::SLEEP_OK_BIT])
        begin
          state_d = pwr_hs_pkg::PWR_SLEEP;
        end
      end
      default: state_d = pwr_hs_pkg::PWR_SLEEP;
    endcase
    awake_d = state_d == pwr_hs_pkg::PWR_AWAKE;
    // R5 host attention, R4 output polarity, R1 only in serial mode
    hostWake_d = uartMode && (attentionReq || ctrl_q[pwr_hs_pkg::SW_HOST_WAKE_BIT]) ?
      ctrl_q[pwr_hs_pkg::HOST_WAKE_POL_BIT] : !ctrl_q[pwr_hs_pkg::HOST_WAKE_POL_BIT];
    // R7 clock request, R8 fixed active high
    clkReq_d = radioClkNeed || ctrl_q[pwr_hs_pkg::SW_CLK_REQ_BIT];
    // R9 per-path power-down, sleep forces all down
    if (state_q != pwr_hs_pkg::PWR_AWAKE)
    begin
      pdOut_d = pwr_hs_pkg::PWRDN_ALL;
    end
    else if (ctrl_q[pwr_hs_pkg::PKT_AUTO_BIT])
    begin
      pdOut_d = pwrdn_q & pktPd;
    end
    else
    begin
      pdOut_d = pwrdn_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= pwr_hs_pkg::CTRL_RESET;
      pwrdn_q <= pwr_hs_pkg::PWRDN_RESET;
      rdata_q <= 32'h0;
      state_q <= pwr_hs_pkg::PWR_SLEEP;
      awake_q <= 1'b0;
      // R12 clkReq and awake low in reset, power-downs all set, host wake at the idle level of its reset polarity
      hostWake_q <= !pwr_hs_pkg::CTRL_RESET[pwr_hs_pkg::HOST_WAKE_POL_BIT];
      clkReq_q <= 1'b0;
      pdOut_q <= pwr_hs_pkg::PWRDN_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      pwrdn_q <= pwrdn_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      awake_q <= awake_d;
      hostWake_q <= hostWake_d;
      clkReq_q <= clkReq_d;
      pdOut_q <= pdOut_d;
    end
  end

  assign regRdata = rdata_q;
  assign host_wake_out = hostWake_q;
  assign clkReq = clkReq_q;
  assign txPowerDown = pdOut_q[pwr_hs_pkg::PD_TX_BIT];
  assign rxPowerDown = pdOut_q[pwr_hs_pkg::PD_RX_BIT];
  assign pllPowerDown = pdOut_q[pwr_hs_pkg::PD_PLL_BIT];
  assign paPowerDown = pdOut_q[pwr_hs_pkg::PD_PA_BIT];
  assign awake = awake_q;

  // R2 wake within bound
  a_wake_forces_awake: assert property (@(posedge core_clk) disable iff (sys_rst)
    wakeAsserted |=> awake) else $error("awake not reached after wake request");
  // R3 no sleep without criteria
  a_sleep_needs_ok: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(awake) |-> $past(ctrl_q[pwr_hs_pkg::SLEEP_OK_BIT]) && !$past(wakeAsserted))
    else $error("slept without criteria");
  // R5 host wake follows attention
  a_host_wake_attn: assert property (@(posedge core_clk) disable iff (sys_rst)
    (attentionReq && uartMode) |=> host_wake_out == $past(ctrl_q[pwr_hs_pkg::HOST_WAKE_POL_BIT]))
    else $error("host wake not asserted");
  // R8 clock request active high
  a_clk_req_high: assert property (@(posedge core_clk) disable iff (sys_rst)
    radioClkNeed |=> clkReq) else $error("clock request missing");
  // R9 sleep powers down all
  a_sleep_all_down: assert property (@(posedge core_clk) disable iff (sys_rst)
    !awake |=> txPowerDown && rxPowerDown && pllPowerDown && paPowerDown)
    else $error("path powered while asleep");
  // R11 tx packet powers tx path
  a_pkt_tx_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    (awake && txActive && ctrl_q[pwr_hs_pkg::PKT_AUTO_BIT]) |=> !txPowerDown && !paPowerDown)
    else $error("tx path not powered in packet");
  // R10 register write steers power-down
  a_reg_pwrdn: assert property (@(posedge core_clk) disable iff (sys_rst)
    (regWrite && regAddr == pwr_hs_pkg::PWRDN_OFFSET) |=> pwrdn_q == $past(regWdata[3:0]))
    else $error("power-down register not written");
  // R1 idle host wake outside serial mode
  a_no_uart_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    !uartMode ##1 !uartMode |-> host_wake_out == !$past(ctrl_q[pwr_hs_pkg::HOST_WAKE_POL_BIT]))
    else $error("host wake active outside serial mode");
endmodule

/* File: hdl/wake_sync.sv */
`timescale 1ns/1ps
// Purpose: Two-flop synchroniser for the device-wake pin
// Assumes: Synchronous active-high reset
// Notes: First stage feeds only the second stage
module wake_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  pwr_sync_if.sync link
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;

  always_comb
  begin
    meta_d = link.rawLevel;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      // Idle pin level of the reset polarity, so no false wake after reset
      meta_q <= !pwr_hs_pkg::CTRL_RESET[pwr_hs_pkg::DEV_WAKE_POL_BIT];
      sync_q <= !pwr_hs_pkg::CTRL_RESET[pwr_hs_pkg::DEV_WAKE_POL_BIT];
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign link.syncLevel = sync_q;
endmodule

/* File: verification/host_model.sv */
// Purpose: Host side of the wake handshake
// Assumes: Polarities mirror the device control bits
// Notes: Drives the wake pin, follows the host-wake line
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk,
  input wire logic hostWake,
  input wire logic devPol,
  input wire logic hostPol,
  input wire logic wakeReq,
  output logic devWake = 1'b0,
  output logic hostAwake = 1'b0
);
  always @(posedge core_clk)
    devWake <= wakeReq ~^ devPol;
  always @(posedge core_clk)
    hostAwake <= hostWake ~^ hostPol;
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the power handshake
// Assumes: Host model drives the wake pin
// Notes: Power-downs packed as {pa, pll, rx, tx}
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata;
  logic devWake, hostAwake, hostWake, clkReq, awake;
  logic txPd, rxPd, pllPd, paPd;
  logic attentionReq = 1'b0;
  logic radioClkNeed = 1'b0;
  logic txActive = 1'b0;
  logic rxActive = 1'b0;
  logic wakeReq = 1'b0;
  logic pol = 1'b0;
  logic [3:0] pdReg;
  logic [3:0] pdE;
  logic a, t, r;
  int n_errors = 0;
  int check_count = 0;
  wire logic [3:0] pd = {paPd, pllPd, rxPd, txPd};
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  radio_host_power_handshake uut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .device_wake_in(devWake), .attentionReq(attentionReq), .radioClkNeed(radioClkNeed),
    .txActive(txActive), .rxActive(rxActive), .host_wake_out(hostWake), .clkReq(clkReq),
    .txPowerDown(txPd), .rxPowerDown(rxPd), .pllPowerDown(pllPd), .paPowerDown(paPd), .awake(awake));
  host_model host (.core_clk(core_clk), .hostWake(hostWake), .devPol(pol), .hostPol(pol),
    .wakeReq(wakeReq), .devWake(devWake), .hostAwake(hostAwake));
  function automatic logic [3:0] pdExp(logic aw, logic [3:0] rg, logic au, logic tx, logic rx);
    if (!aw)
      return pwr_hs_pkg::PWRDN_ALL;
    if (!au)
      return rg;
    return rg & (tx ? pwr_hs_pkg::PWRDN_TX_ON : pwr_hs_pkg::PWRDN_ALL) &
      (rx ? pwr_hs_pkg::PWRDN_RX_ON : pwr_hs_pkg::PWRDN_ALL);
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [3:0] ad, logic [31:0] d);
    @(posedge core_clk);
    regAddr <= ad;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(logic [3:0] ad, logic [31:0] e);
    @(posedge core_clk);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk("regRdata", e, regRdata);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_errors++;
    test_done;
  end
  initial
  begin
    void'($urandom(32'h7324));
    cyc(4);
    chk("resetOut", {26'h0, !pwr_hs_pkg::CTRL_RESET[pwr_hs_pkg::HOST_WAKE_POL_BIT], 1'b0, pwr_hs_pkg::PWRDN_RESET},
      {hostWake, clkReq, pd});
    @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(pwr_hs_pkg::CTRL_OFFSET, {25'h0, pwr_hs_pkg::CTRL_RESET});
    rd(pwr_hs_pkg::PWRDN_OFFSET, {28'h0, pwr_hs_pkg::PWRDN_RESET});
    rd(4'hc, 32'h0);
    wr(pwr_hs_pkg::CTRL_OFFSET, 32'h10);
    cyc(5);
    chk("awakeNoSerial", 1'b1, awake);
    for (int p = 0; p < 2; p++)
    begin
      pol <= p[0];
      wr(pwr_hs_pkg::CTRL_OFFSET, 32'h30 | (p * 3));
      wakeReq <= 1'b1;
      attentionReq <= 1'b1;
      cyc(6);
      chk("awakeOnWake", 1'b1, awake);
      chk("hostAwake", 1'b1, hostAwake);
      wakeReq <= 1'b0;
      attentionReq <= 1'b0;
      cyc(6);
      chk("awakeAsleep", 1'b0, awake);
      chk("hostReleased", 1'b0, hostAwake);
      chk("pdAsleep", pdExp(1'b0, 4'h0, 1'b0, 1'b0, 1'b0), pd);
    end
    for (int i = 0; i < 16; i++)
    begin
      radioClkNeed <= 1'($urandom);
      cyc(2);
      chk("clkReq", radioClkNeed, clkReq);
    end
    radioClkNeed <= 1'b0;
    wr(pwr_hs_pkg::CTRL_OFFSET, 32'h3f);
    cyc(2);
    chk("clkReqSw", 1'b1, clkReq);
    chk("hostWakeSw", 1'b1, hostWake);
    wakeReq <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      {a, t, r} = 3'($urandom);
      a = a | (i < 2);
      pdReg = (i < 2) ? 4'hf : 4'($urandom);
      wr(pwr_hs_pkg::CTRL_OFFSET, 32'h33 | (a << 6));
      wr(pwr_hs_pkg::PWRDN_OFFSET, {28'h0, pdReg});
      txActive <= t | (i == 0);
      rxActive <= r;
      cyc(4);
      pdE = pdExp(1'b1, pdReg, a, t | (i == 0), r);
      chk("powerDown", pdE, pd);
      rd(pwr_hs_pkg::STATUS_OFFSET, {24'h0, pdE, 4'h3});
    end
    test_done;
  end
endmodule
